// >>> inc/tvi_pkg.sv
// shared constants for the translation, vector and pending-status register bank
package tvi_pkg;
    // coprocessor register selectors {crn, op1, crm, op2}
    localparam logic [3:0] CRN_C7     = 4'h7;
    localparam logic [3:0] CRN_C12    = 4'hC;
    localparam logic [3:0] CRM_C0     = 4'h0;
    localparam logic [3:0] CRM_C1     = 4'h1;
    localparam logic [3:0] CRM_C4     = 4'h4;
    localparam logic [3:0] CRM_C5     = 4'h5;
    localparam logic [3:0] CRM_C10    = 4'hA;
    localparam logic [2:0] OP1_ZERO   = 3'h0;
    localparam logic [2:0] OP2_RESULT = 3'h0;
    localparam logic [2:0] OP2_VBASE  = 3'h0;
    localparam logic [2:0] OP2_MVBASE = 3'h1;
    localparam logic [2:0] OP2_PEND   = 3'h0;
    localparam logic [2:0] OP2_VTRIG  = 3'h1;
    localparam logic [2:0] OP2_ISYNC  = 3'h4;
    localparam logic [2:0] OP2_DSYNC  = 3'h4;
    localparam logic [2:0] OP2_DMEM   = 3'h5;
    // translation result fields
    localparam int RES_FAIL_BIT  = 0;
    localparam int RES_SUPER_BIT = 1;
    localparam int RES_OUTER_LO  = 2;
    localparam int RES_INNER_LO  = 4;
    localparam int RES_SHARE_BIT = 7;
    localparam int RES_NSEC_BIT  = 9;
    localparam int RES_ADDR_LO   = 12;
    localparam int RES_FS_LO     = 1;
    localparam int RES_EXT_BIT   = 12;
    localparam int VBASE_LO      = 5;
    // pending status / virtual trigger fields
    localparam int PEND_FIQ_BIT  = 6;
    localparam int PEND_IRQ_BIT  = 7;
    localparam int PEND_ABT_BIT  = 8;
    localparam logic [31:0] RESULT_RST = 32'h0000_0000;
    localparam logic [31:0] VBASE_RST  = 32'h0000_0000;
    localparam logic [2:0]  VTRIG_RST  = 3'h0;
    localparam logic [2:0]  OUTER_NORMAL = 3'h2;
endpackage

// >>> hw/tvi_xlt_fmt.sv
// packs a translation outcome into the translation result word
module tvi_xlt_fmt (
    input  wire logic        ABORT,
    input  wire logic [19:0] PHYS_ADDR,
    input  wire logic        NS_IND,
    input  wire logic        SHAREABLE,
    input  wire logic [2:0]  INNER_ATTR,
    input  wire logic [1:0]  OUTER_ATTR,
    input  wire logic        SUPERSECTION,
    input  wire logic [5:0]  FAULT_STATUS,
    input  wire logic        EXT_ABORT_TYPE,
    output logic      [31:0] RESULT
);
    logic [31:0] ok_word;
    logic [31:0] abort_word;

    // success format; reserved bits 11:10 and 8 forced to zero
    assign ok_word = {PHYS_ADDR, 2'b00, NS_IND, 1'b0, SHAREABLE,
                      INNER_ATTR, OUTER_ATTR, SUPERSECTION, 1'b0};
    // abort format: fault status code and abort type, failure bit set
    assign abort_word = {19'h0, EXT_ABORT_TYPE, 5'h0, FAULT_STATUS, 1'b1};
    assign RESULT = ABORT ? abort_word : ok_word;
endmodule // tvi_xlt_fmt

// >>> hw/tvi_pend.sv
// selects physical or virtual pending conditions for the status word
module tvi_pend (
    input  wire logic       NONSECURE,
    input  wire logic [2:0] PHYS_PEND,
    input  wire logic [2:0] ROUTE_MON,
    input  wire logic [2:0] MASK_OVR,
    input  wire logic [2:0] VTRIG,
    output logic      [2:0] PEND
);
    // bit order in all vectors: {abort, irq, fiq}
    genvar i;
    generate
        for (i = 0; i < 3; i++) begin : g_src
            wire logic use_virt;
            assign use_virt = NONSECURE & ROUTE_MON[i] & MASK_OVR[i];
            assign PEND[i]  = use_virt ? VTRIG[i] : PHYS_PEND[i];
        end
    endgenerate
endmodule // tvi_pend

// >>> hw/tvi_regs.sv
// translation result, vector base and interrupt pending register bank
module tvi_regs (
    input  wire logic        CORE_CLK,
    input  wire logic        RESETN,
    input  wire logic        ACC_VALID,
    input  wire logic        ACC_WRITE,
    input  wire logic [3:0]  ACC_CRN,
    input  wire logic [2:0]  ACC_OP1,
    input  wire logic [3:0]  ACC_CRM,
    input  wire logic [2:0]  ACC_OP2,
    input  wire logic [31:0] ACC_WDATA,
    input  wire logic        ACC_PRIV,
    input  wire logic        CUR_NS,
    output logic             ACC_DONE,
    output logic             ACC_UNDEF,
    output logic      [31:0] ACC_RDATA,
    input  wire logic        XLT_DONE,
    input  wire logic        XLT_BANK_NS,
    input  wire logic        XLT_ABORT,
    input  wire logic [19:0] XLT_PHYS_ADDR,
    input  wire logic        XLT_NS_IND,
    input  wire logic        XLT_SHAREABLE,
    input  wire logic [2:0]  XLT_INNER,
    input  wire logic [1:0]  XLT_OUTER,
    input  wire logic        XLT_SUPERSECTION,
    input  wire logic [5:0]  XLT_FAULT_STATUS,
    input  wire logic        XLT_EXT_ABORT_TYPE,
    input  wire logic        PHYS_ABORT_PEND,
    input  wire logic        PHYS_IRQ_PEND,
    input  wire logic        PHYS_FIQ_PEND,
    input  wire logic [2:0]  SECURE_CONFIG_ROUTE,
    input  wire logic [2:0]  MASK_OVERRIDE,
    input  wire logic        VIRT_ABORT_TAKEN,
    output logic      [31:0] VECTOR_BASE,
    output logic      [31:0] MON_VECTOR_BASE,
    output logic      [2:0]  PENDING
);
    logic [31:0] res_s_q, res_s_d;
    logic [31:0] res_ns_q, res_ns_d;
    logic [26:0] vb_s_q, vb_s_d;
    logic [26:0] vb_ns_q, vb_ns_d;
    logic [26:0] mvb_q, mvb_d;
    logic [2:0]  vtrig_q, vtrig_d;
    logic [31:0] rdata_q, rdata_d;
    logic        done_q, undef_q;
    logic [31:0] res_word;
    logic [2:0]  pend;

    tvi_xlt_fmt u_fmt (
        .ABORT          (XLT_ABORT),
        .PHYS_ADDR      (XLT_PHYS_ADDR),
        .NS_IND         (XLT_NS_IND),
        .SHAREABLE      (XLT_SHAREABLE),
        .INNER_ATTR     (XLT_INNER),
        .OUTER_ATTR     (XLT_OUTER),
        .SUPERSECTION   (XLT_SUPERSECTION),
        .FAULT_STATUS   (XLT_FAULT_STATUS),
        .EXT_ABORT_TYPE (XLT_EXT_ABORT_TYPE),
        .RESULT         (res_word)
    );

    tvi_pend u_pend (
        .NONSECURE (CUR_NS),
        .PHYS_PEND ({PHYS_ABORT_PEND, PHYS_IRQ_PEND, PHYS_FIQ_PEND}),
        .ROUTE_MON (SECURE_CONFIG_ROUTE),
        .MASK_OVR  (MASK_OVERRIDE),
        .VTRIG     (vtrig_q),
        .PEND      (pend)
    );

    // address decode of the coprocessor selector
    wire logic op1_ok   = (ACC_OP1 == tvi_pkg::OP1_ZERO);
    wire logic sel_res  = op1_ok && (ACC_CRN == tvi_pkg::CRN_C7) && (ACC_CRM == tvi_pkg::CRM_C4)
                          && (ACC_OP2 == tvi_pkg::OP2_RESULT);
    wire logic sel_vb   = op1_ok && (ACC_CRN == tvi_pkg::CRN_C12) && (ACC_CRM == tvi_pkg::CRM_C0)
                          && (ACC_OP2 == tvi_pkg::OP2_VBASE);
    wire logic sel_mvb  = op1_ok && (ACC_CRN == tvi_pkg::CRN_C12) && (ACC_CRM == tvi_pkg::CRM_C0)
                          && (ACC_OP2 == tvi_pkg::OP2_MVBASE);
    wire logic sel_pend = op1_ok && (ACC_CRN == tvi_pkg::CRN_C12) && (ACC_CRM == tvi_pkg::CRM_C1)
                          && (ACC_OP2 == tvi_pkg::OP2_PEND);
    wire logic sel_vtrg = op1_ok && (ACC_CRN == tvi_pkg::CRN_C12) && (ACC_CRM == tvi_pkg::CRM_C1)
                          && (ACC_OP2 == tvi_pkg::OP2_VTRIG);
    // deprecated barrier selectors, writes accepted with no effect, reads refused
    wire logic sel_bar  = op1_ok && (ACC_CRN == tvi_pkg::CRN_C7) && ACC_WRITE
                          && (((ACC_CRM == tvi_pkg::CRM_C10) && ((ACC_OP2 == tvi_pkg::OP2_DSYNC)
                          || (ACC_OP2 == tvi_pkg::OP2_DMEM)))
                          || ((ACC_CRM == tvi_pkg::CRM_C5) && (ACC_OP2 == tvi_pkg::OP2_ISYNC)));
    wire logic sel_any  = sel_res | sel_vb | sel_mvb | sel_pend | sel_vtrg | sel_bar;

    // monitor base is reachable from secure state only; everything needs privilege
    wire logic mvb_block = sel_mvb & CUR_NS;
    wire logic refuse    = !ACC_PRIV || !sel_any || mvb_block;
    wire logic acc_ok    = ACC_VALID & !refuse;
    wire logic wr_ok     = acc_ok & ACC_WRITE;

    // reads: banked copies follow the current security state
    wire logic [31:0] res_cur = CUR_NS ? res_ns_q : res_s_q;
    wire logic [26:0] vb_cur  = CUR_NS ? vb_ns_q : vb_s_q;
    wire logic [31:0] pend_word = {23'h0, pend, 6'h0};
    wire logic [31:0] vtrg_word = {23'h0, vtrig_q, 6'h0};
    wire logic [31:0] rd_mux =
        sel_res  ? res_cur :
        sel_vb   ? {vb_cur, 5'h00} :
        sel_mvb  ? {mvb_q, 5'h00} :
        sel_pend ? pend_word :
        sel_vtrg ? vtrg_word : 32'h0000_0000;

    // write enables; result and pending words have no write path
    wire logic wr_vb   = wr_ok & sel_vb;
    wire logic wr_mvb  = wr_ok & sel_mvb;
    wire logic wr_vtrg = wr_ok & sel_vtrg;

    // translation result captured per bank when a translation completes
    always_comb begin
        res_s_d  = res_s_q;
        res_ns_d = res_ns_q;
        if (XLT_DONE && XLT_BANK_NS) begin
            res_ns_d = res_word;
        end else if (XLT_DONE) begin
            res_s_d = res_word;
        end
    end

    // banked vector base: a write lands in the copy of the current state
    always_comb begin
        vb_s_d  = vb_s_q;
        vb_ns_d = vb_ns_q;
        mvb_d   = mvb_q;
        if (wr_vb && CUR_NS) begin
            vb_ns_d = ACC_WDATA[31:tvi_pkg::VBASE_LO];
        end else if (wr_vb) begin
            vb_s_d = ACC_WDATA[31:tvi_pkg::VBASE_LO];
        end
        if (wr_mvb) begin
            mvb_d = ACC_WDATA[31:tvi_pkg::VBASE_LO];
        end
    end

    // virtual trigger: software write wins over the hardware abort clear,
    // so a trigger re-armed in the taking cycle is not lost
    always_comb begin
        vtrig_d = vtrig_q;
        if (VIRT_ABORT_TAKEN) begin
            vtrig_d[2] = 1'b0;
        end
        if (wr_vtrg) begin
            vtrig_d = ACC_WDATA[tvi_pkg::PEND_ABT_BIT:tvi_pkg::PEND_FIQ_BIT];
        end
    end

    assign rdata_d = (acc_ok && !ACC_WRITE) ? rd_mux : rdata_q;

    // storage
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            res_s_q  <= tvi_pkg::RESULT_RST;
            res_ns_q <= tvi_pkg::RESULT_RST;
            vb_s_q   <= tvi_pkg::VBASE_RST[31:5];
            vb_ns_q  <= tvi_pkg::VBASE_RST[31:5];
            mvb_q    <= tvi_pkg::VBASE_RST[31:5];
            vtrig_q  <= tvi_pkg::VTRIG_RST;
        end else begin
            res_s_q  <= res_s_d;
            res_ns_q <= res_ns_d;
            vb_s_q   <= vb_s_d;
            vb_ns_q  <= vb_ns_d;
            mvb_q    <= mvb_d;
            vtrig_q  <= vtrig_d;
        end
    end

    // one-cycle answer to each access
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            rdata_q <= 32'h0000_0000;
            done_q  <= 1'b0;
            undef_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            done_q  <= acc_ok;
            undef_q <= ACC_VALID & refuse;
        end
    end

    assign ACC_DONE        = done_q;
    assign ACC_UNDEF       = undef_q;
    assign ACC_RDATA       = rdata_q;
    assign VECTOR_BASE     = {vb_cur, 5'h00};
    assign MON_VECTOR_BASE = {mvb_q, 5'h00};
    assign PENDING         = pend;

    // checks; every property is on the core clock and quiet while reset is held
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESETN);

    // translation capture: outcome flag, field placement and bank choice
    // success and abort share bits, so each format is checked on the bank it went to
    a_fail_bit_set: assert property (XLT_DONE && !XLT_BANK_NS
        |=> res_s_q[0] == $past(XLT_ABORT))
        else $error("failure bit does not match translation outcome");
    a_res_reserved: assert property (!res_ns_q[0]
        |-> res_ns_q[11:10] == 2'b00 && !res_ns_q[8])
        else $error("reserved result bits not zero");
    a_res_rsvd_sec: assert property (!res_s_q[0]
        |-> res_s_q[11:10] == 2'b00 && !res_s_q[8])
        else $error("reserved secure result bits not zero");
    a_pa_capture: assert property (XLT_DONE && XLT_BANK_NS && !XLT_ABORT
        |=> res_ns_q[31:12] == $past(XLT_PHYS_ADDR) && res_ns_q[9] == $past(XLT_NS_IND))
        else $error("address or non-secure bit not captured");
    a_attr_fields: assert property (XLT_DONE && !XLT_BANK_NS && !XLT_ABORT
        |=> res_s_q[6:4] == $past(XLT_INNER) && res_s_q[3:2] == $past(XLT_OUTER))
        else $error("region attributes not captured");
    a_share_super: assert property (XLT_DONE && !XLT_BANK_NS && !XLT_ABORT
        |=> res_s_q[7] == $past(XLT_SHAREABLE) && res_s_q[1] == $past(XLT_SUPERSECTION))
        else $error("shareable or supersection bit not captured");
    a_abort_fields: assert property (XLT_DONE && XLT_BANK_NS && XLT_ABORT
        |=> res_ns_q[0] && res_ns_q[6:1] == $past(XLT_FAULT_STATUS) && res_ns_q[12] == $past(XLT_EXT_ABORT_TYPE))
        else $error("abort source not captured");
    a_res_hold: assert property (!XLT_DONE
        |=> $stable(res_s_q) && $stable(res_ns_q))
        else $error("result changed without a translation");

    // access answers: exactly one of done and refuse, one cycle after the request
    // bank is judged by the state at the request, since the state may move next cycle
    a_res_read: assert property (ACC_VALID && ACC_PRIV && !ACC_WRITE && sel_res && !XLT_DONE
        |=> ACC_DONE && ACC_RDATA == ($past(CUR_NS) ? res_ns_q : res_s_q))
        else $error("result read returned wrong bank");
    a_answer_once: assert property (ACC_VALID
        |=> ACC_DONE != ACC_UNDEF)
        else $error("access not answered by exactly one of done and refuse");
    a_no_answer: assert property (!ACC_VALID
        |=> !ACC_DONE && !ACC_UNDEF && $stable(ACC_RDATA))
        else $error("answer or read data change without an access");
    a_unpriv_undef: assert property (ACC_VALID && !ACC_PRIV
        |=> ACC_UNDEF && !ACC_DONE && $stable(vb_s_q) && $stable(vb_ns_q) && $stable(mvb_q))
        else $error("unprivileged access not refused");
    a_barrier_nop: assert property (ACC_VALID && ACC_PRIV && sel_bar
        |=> ACC_DONE && !ACC_UNDEF && $stable(vb_s_q) && $stable(vb_ns_q) && $stable(mvb_q))
        else $error("barrier operation not a plain no-op");

    // vector bases: a write lands only in the copy of the current state
    // reserved low bits are never stored, so they always read back as zero
    a_vbase_bank: assert property (VECTOR_BASE[4:0] == 5'h00
        && VECTOR_BASE[31:5] == (CUR_NS ? vb_ns_q : vb_s_q))
        else $error("vector base from wrong bank");
    a_vb_write_sec: assert property (wr_vb && !CUR_NS
        |=> vb_s_q == $past(ACC_WDATA[31:tvi_pkg::VBASE_LO]) && $stable(vb_ns_q))
        else $error("secure vector base write misplaced");
    a_vb_write_ns: assert property (wr_vb && CUR_NS
        |=> vb_ns_q == $past(ACC_WDATA[31:tvi_pkg::VBASE_LO]) && $stable(vb_s_q))
        else $error("non-secure vector base write misplaced");
    a_mvb_write: assert property (wr_mvb
        |=> MON_VECTOR_BASE == {$past(ACC_WDATA[31:tvi_pkg::VBASE_LO]), 5'h00})
        else $error("monitor base write not stored");
    a_mvb_refuse: assert property (ACC_VALID && sel_mvb && CUR_NS
        |=> ACC_UNDEF && $stable(mvb_q))
        else $error("non-secure monitor base access not refused");

    // pending status and virtual triggers; triggers move only by write or abort take
    // a trigger write racing an abort take is excluded where the write would win
    a_virt_pend: assert property (CUR_NS && SECURE_CONFIG_ROUTE[1] && MASK_OVERRIDE[1]
        |-> PENDING[1] == vtrig_q[1])
        else $error("routed IRQ not reported from virtual trigger");
    a_phys_pend: assert property (!CUR_NS
        |-> PENDING == {PHYS_ABORT_PEND, PHYS_IRQ_PEND, PHYS_FIQ_PEND})
        else $error("secure state pending not physical");
    a_pend_read: assert property (ACC_VALID && ACC_PRIV && !ACC_WRITE && sel_pend
        |=> ACC_DONE && ACC_RDATA == {23'h0, $past(PENDING), 6'h00})
        else $error("pending status read wrong");
    a_vtrig_hold: assert property (!VIRT_ABORT_TAKEN && !wr_vtrg
        |=> $stable(vtrig_q))
        else $error("virtual trigger changed on its own");
    a_vabort_clear: assert property (VIRT_ABORT_TAKEN && !wr_vtrg
        |=> !vtrig_q[2] && vtrig_q[1:0] == $past(vtrig_q[1:0]))
        else $error("taken virtual abort handling wrong");
    a_ro_write: assert property (ACC_VALID && ACC_WRITE && (sel_res || sel_pend)
        && !XLT_DONE && !VIRT_ABORT_TAKEN |=> $stable(res_s_q) && $stable(res_ns_q) && $stable(vtrig_q))
        else $error("write changed a read-only register");
endmodule // tvi_regs

// >>> verification/tvi_pipe_model.sv
// pipeline model issuing coprocessor register accesses
module tvi_pipe_model (
    input  wire logic        CLK,
    input  wire logic        DONE,
    input  wire logic        UNDEF,
    input  wire logic [31:0] RDATA,
    output logic             VALID,
    output logic             WRITE,
    output logic      [13:0] SEL,
    output logic      [31:0] WDATA,
    output logic             PRIV,
    output logic             NS
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle, privileged, secure at time zero
    initial begin
        VALID = 1'b0;
        WRITE = 1'b0;
        SEL   = 14'h0000;
        WDATA = 32'h0000_0000;
        PRIV  = 1'b1;
        NS    = 1'b0;
    end
    // one access held up to its answer edge; mode and state stay put afterwards
    task automatic access(input logic w, input logic [13:0] s, input logic [31:0] wd, input logic p,
                          input logic n, output logic dn, output logic un, output logic [31:0] rd);
        @(posedge CLK);
        VALID <= 1'b1;
        WRITE <= w;
        SEL   <= s;
        WDATA <= wd;
        PRIV  <= p;
        NS    <= n;
        @(posedge CLK);
        VALID <= 1'b0;
        WDATA <= ~wd; // released data never repeats the last word
        #1;
        dn = DONE;
        un = UNDEF;
        rd = RDATA;
    endtask
endmodule // tvi_pipe_model

// >>> verification/translation_vector_irq_status_regs_test.sv
// self-checking bench for the translation, vector and pending register bank
module translation_vector_irq_status_regs_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [13:0] RES  = {tvi_pkg::CRN_C7, tvi_pkg::OP1_ZERO, tvi_pkg::CRM_C4, tvi_pkg::OP2_RESULT};
    localparam logic [13:0] VB   = {tvi_pkg::CRN_C12, tvi_pkg::OP1_ZERO, tvi_pkg::CRM_C0, tvi_pkg::OP2_VBASE};
    localparam logic [13:0] MVB  = {tvi_pkg::CRN_C12, tvi_pkg::OP1_ZERO, tvi_pkg::CRM_C0, tvi_pkg::OP2_MVBASE};
    localparam logic [13:0] PND  = {tvi_pkg::CRN_C12, tvi_pkg::OP1_ZERO, tvi_pkg::CRM_C1, tvi_pkg::OP2_PEND};
    localparam logic [13:0] VTR  = {tvi_pkg::CRN_C12, tvi_pkg::OP1_ZERO, tvi_pkg::CRM_C1, tvi_pkg::OP2_VTRIG};
    localparam logic [13:0] NOSL = {4'hC, 3'h0, 4'h0, 3'h2};
    logic        core_clk, resetn, valid, write, priv, ns, done, undef;
    logic        xd, xbank, xab, xns, xsh, xss, xext, pab, pirq, pfiq, vtaken;
    logic [13:0] sel;
    logic [2:0]  xin, route, mask, pend;
    logic [1:0]  xout;
    logic [5:0]  xfs;
    logic [19:0] xpa;
    logic [31:0] wdata, rdata, vbase, mvbase, rd;
    int          n_fail, checks_done;

    tvi_pipe_model u_pipe (.CLK(core_clk), .DONE(done), .UNDEF(undef), .RDATA(rdata), .VALID(valid),
        .WRITE(write), .SEL(sel), .WDATA(wdata), .PRIV(priv), .NS(ns));
    tvi_regs u_dut (.CORE_CLK(core_clk), .RESETN(resetn), .ACC_VALID(valid), .ACC_WRITE(write),
        .ACC_CRN(sel[13:10]), .ACC_OP1(sel[9:7]), .ACC_CRM(sel[6:3]), .ACC_OP2(sel[2:0]), .ACC_WDATA(wdata),
        .ACC_PRIV(priv), .CUR_NS(ns), .ACC_DONE(done), .ACC_UNDEF(undef), .ACC_RDATA(rdata), .XLT_DONE(xd),
        .XLT_BANK_NS(xbank), .XLT_ABORT(xab), .XLT_PHYS_ADDR(xpa), .XLT_NS_IND(xns), .XLT_SHAREABLE(xsh),
        .XLT_INNER(xin), .XLT_OUTER(xout), .XLT_SUPERSECTION(xss), .XLT_FAULT_STATUS(xfs),
        .XLT_EXT_ABORT_TYPE(xext), .PHYS_ABORT_PEND(pab), .PHYS_IRQ_PEND(pirq), .PHYS_FIQ_PEND(pfiq),
        .SECURE_CONFIG_ROUTE(route), .MASK_OVERRIDE(mask), .VIRT_ABORT_TAKEN(vtaken),
        .VECTOR_BASE(vbase), .MON_VECTOR_BASE(mvbase), .PENDING(pend));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // access with expected answer: 1 accepted, 2 refused; read data judged when cmp set
    task automatic acc(input logic w, input logic [13:0] s, input logic [31:0] wd, input logic p, input logic n,
                       input logic [1:0] er, input logic cmp, input logic [31:0] ed);
        logic dn, un;
        u_pipe.access(w, s, wd, p, n, dn, un, rd);
        chk({30'h0, un, dn}, {30'h0, er}, "answer");
        if (cmp) begin
            chk(rd, ed, "read data");
        end
    endtask
    task automatic xlt(input logic b, input logic a, input logic [19:0] pa, input logic [2:0] f,
                       input logic [2:0] in, input logic [1:0] ou, input logic [5:0] fs);
        @(posedge core_clk);
        xd <= 1'b1;
        xbank <= b;
        xab <= a;
        xpa <= pa;
        {xns, xsh, xss} <= f;
        xin <= in;
        xout <= ou;
        xfs <= fs;
        xext <= f[0];
        @(posedge core_clk);
        xd <= 1'b0;
    endtask
    // translation word formats and banking
    task automatic t_result;
        logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h6, 3'h7};
        logic [31:0] w;
        for (int i = 0; i < 6; i++) begin
            xlt(1'b0, 1'b0, 20'hABCDE ^ 20'(i), 3'(i), codes[i], 2'(i), 6'h3F);
            w = {20'hABCDE ^ 20'(i), 2'b00, 1'(i >> 2), 1'b0, 1'(i >> 1), codes[i], 2'(i), 1'(i), 1'b0};
            acc(1'b0, RES, 32'h0, 1'b1, 1'b0, 2'b01, 1'b1, w);
        end
        xlt(1'b1, 1'b1, 20'hFFFFF, 3'h7, 3'h7, 2'h3, 6'h2D);
        acc(1'b0, RES, 32'h0, 1'b1, 1'b1, 2'b01, 1'b1, 32'h0000_105B);
        acc(1'b0, RES, 32'h0, 1'b1, 1'b0, 2'b01, 1'b1, w);
        acc(1'b1, RES, 32'hFFFF_FFFF, 1'b1, 1'b0, 2'b01, 1'b0, 32'h0);
        acc(1'b0, RES, 32'h0, 1'b0, 1'b0, 2'b10, 1'b0, 32'h0);
        acc(1'b0, RES, 32'h0, 1'b1, 1'b0, 2'b01, 1'b1, w);
        xlt(1'b1, 1'b0, 20'h13579, 3'h4, 3'h3, 2'h2, 6'h00);
        acc(1'b0, RES, 32'h0, 1'b1, 1'b1, 2'b01, 1'b1, 32'h1357_9238);
        $display("test result done");
    endtask
    // banked vector bases, monitor base and refusals
    task automatic t_vbase;
        acc(1'b0, VB, 32'h0, 1'b1, 1'b0, 2'b01, 1'b1, 32'h0);
        acc(1'b1, VB, 32'hFFFF_FFFF, 1'b1, 1'b0, 2'b01, 1'b0, 32'h0);
        acc(1'b1, VB, 32'h1234_5660, 1'b1, 1'b1, 2'b01, 1'b0, 32'h0);
        chk(vbase, 32'h1234_5660, "non-secure base");
        acc(1'b1, VB, 32'h0000_0040, 1'b0, 1'b0, 2'b10, 1'b0, 32'h0);
        chk(vbase, 32'hFFFF_FFE0, "secure base");
        acc(1'b0, VB, 32'h0, 1'b1, 1'b0, 2'b01, 1'b1, 32'hFFFF_FFE0);
        acc(1'b1, MVB, 32'h8000_0020, 1'b1, 1'b0, 2'b01, 1'b0, 32'h0);
        acc(1'b1, MVB, 32'h0000_0100, 1'b1, 1'b1, 2'b10, 1'b0, 32'h0);
        chk(mvbase, 32'h8000_0020, "monitor base");
        acc(1'b0, NOSL, 32'h0, 1'b1, 1'b0, 2'b10, 1'b0, 32'h0);
        $display("test vbase done");
    endtask
    // deprecated barriers: writes are no-ops, reads refused
    task automatic t_barrier;
        logic [13:0] b [3] = '{{4'h7, 3'h0, 4'hA, 3'h4}, {4'h7, 3'h0, 4'hA, 3'h5}, {4'h7, 3'h0, 4'h5, 3'h4}};
        for (int i = 0; i < 3; i++) begin
            acc(1'b1, b[i], 32'h0, 1'b1, 1'b0, 2'b01, 1'b0, 32'h0);
            acc(1'b0, b[i], 32'h0, 1'b1, 1'b0, 2'b10, 1'b0, 32'h0);
        end
        chk(vbase, 32'hFFFF_FFE0, "base after barriers");
        $display("test barrier done");
    endtask
    task automatic pset(input logic [2:0] p, input logic [2:0] r, input logic [2:0] m);
        @(posedge core_clk);
        {pab, pirq, pfiq} <= p;
        route <= r;
        mask <= m;
    endtask
    // status read in the given state; also judges the live pending lines
    task automatic pchk(input logic n, input logic [2:0] e);
        acc(1'b0, PND, 32'h0, 1'b1, n, 2'b01, 1'b1, {23'h0, e, 6'h00});
        chk({29'h0, pend}, {29'h0, e}, "pending lines");
    endtask
    task automatic t_pend;
        pset(3'b101, 3'b111, 3'b111);
        pchk(1'b0, 3'b101);
        acc(1'b1, VTR, 32'h0000_01C0, 1'b1, 1'b0, 2'b01, 1'b0, 32'h0);
        pchk(1'b0, 3'b101);
        pchk(1'b1, 3'b111);
        pset(3'b000, 3'b011, 3'b111);
        pchk(1'b1, 3'b011);
        pset(3'b000, 3'b111, 3'b110);
        pchk(1'b1, 3'b110);
        acc(1'b1, PND, 32'hFFFF_FFFF, 1'b1, 1'b1, 2'b01, 1'b0, 32'h0);
        @(posedge core_clk);
        vtaken <= 1'b1;
        @(posedge core_clk);
        vtaken <= 1'b0;
        pchk(1'b1, 3'b010);
        acc(1'b0, VTR, 32'h0, 1'b1, 1'b1, 2'b01, 1'b1, 32'h0000_00C0);
        acc(1'b1, VTR, 32'h0, 1'b1, 1'b1, 2'b01, 1'b0, 32'h0);
        pchk(1'b1, 3'b000);
        acc(1'b0, PND, 32'h0, 1'b0, 1'b1, 2'b10, 1'b0, 32'h0);
        $display("test pend done");
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // 25 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    // a hang counts as a mismatch
    initial begin
        #2ms;
        n_fail++;
        tally_and_finish();
    end
    initial begin
        {resetn, xd, xbank, xab, xns, xsh, xss, xext, pab, pirq, pfiq, vtaken} = 12'h000;
        {xin, route, mask, xout, xfs, xpa} = 37'h0;
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        #1;
        chk(vbase | mvbase, 32'h0, "bases after reset");
        t_result();
        t_vbase();
        t_barrier();
        t_pend();
        tally_and_finish();
    end
endmodule // translation_vector_irq_status_regs_test
